// File: common/losc_pkg.sv
// Package for the LO synthesizer control block: register map, fields, timing.
// Assumes a 50 MHz system clock and a serial port clocked by the host.
package losc_pkg;
   // Register addresses (16-bit serial address space)
   localparam logic [15:0] ADDR_SERIAL_PORT_CONFIG = 16'h0000;
   localparam logic [15:0] ADDR_IO_LEVEL_SELECT_A = 16'h0101;
   localparam logic [15:0] ADDR_SYNTH_BLOCK_ENABLES = 16'h1021;
   localparam logic [15:0] ADDR_WHOLE_DIVIDE_LOW = 16'h1200;
   localparam logic [15:0] ADDR_WHOLE_DIVIDE_HIGH = 16'h1201;
   localparam logic [15:0] ADDR_PRIMARY_FRACTION_LOW = 16'h1202;
   localparam logic [15:0] ADDR_PRIMARY_FRACTION_MID = 16'h1203;
   localparam logic [15:0] ADDR_PRIMARY_FRACTION_HIGH = 16'h1204;
   localparam logic [15:0] ADDR_AUX_DENOMINATOR_LOW = 16'h1208;
   localparam logic [15:0] ADDR_AUX_DENOMINATOR_HIGH = 16'h1209;
   localparam logic [15:0] ADDR_FEEDBACK_DIVIDER_CTRL = 16'h120B;
   localparam logic [15:0] ADDR_REFERENCE_COUNTER = 16'h120C;
   localparam logic [15:0] ADDR_REFERENCE_PATH_CTRL = 16'h120E;
   localparam logic [15:0] ADDR_VCO_CORE_SELECT = 16'h1217;
   localparam logic [15:0] ADDR_CALIBRATION_CTRL = 16'h121F;
   localparam logic [15:0] ADDR_MODULATOR_CTRL = 16'h122A;
   localparam logic [15:0] ADDR_DETECTOR_PUMP_ENABLE = 16'h122D;
   localparam logic [15:0] ADDR_PUMP_CURRENT = 16'h122E;
   localparam logic [15:0] ADDR_BLEED_CURRENT = 16'h122F;
   localparam logic [15:0] ADDR_AUX_NUMERATOR_LOW = 16'h1233;
   localparam logic [15:0] ADDR_AUX_NUMERATOR_HIGH = 16'h1234;
   localparam logic [15:0] ADDR_VCO_ADJUST_CTRL = 16'h1240;
   localparam logic [15:0] ADDR_LOCK_STATUS = 16'h124D;
   localparam logic [15:0] ADDR_IO_LEVEL_SELECT_B = 16'h1401;
   localparam logic [15:0] ADDR_LO_OUTPUT_CTRL = 16'h1414;

   // Register storage indices
   localparam int NUM_REGS = 24;
   localparam logic [4:0] IDX_SPC = 5'h00;
   localparam logic [4:0] IDX_IOA = 5'h01;
   localparam logic [4:0] IDX_SBE = 5'h02;
   localparam logic [4:0] IDX_WDL = 5'h03;
   localparam logic [4:0] IDX_WDH = 5'h04;
   localparam logic [4:0] IDX_PFL = 5'h05;
   localparam logic [4:0] IDX_PFM = 5'h06;
   localparam logic [4:0] IDX_PFH = 5'h07;
   localparam logic [4:0] IDX_ADL = 5'h08;
   localparam logic [4:0] IDX_ADH = 5'h09;
   localparam logic [4:0] IDX_FBC = 5'h0A;
   localparam logic [4:0] IDX_RCN = 5'h0B;
   localparam logic [4:0] IDX_RPC = 5'h0C;
   localparam logic [4:0] IDX_VCS = 5'h0D;
   localparam logic [4:0] IDX_CAL = 5'h0E;
   localparam logic [4:0] IDX_MOD = 5'h0F;
   localparam logic [4:0] IDX_DPE = 5'h10;
   localparam logic [4:0] IDX_PCU = 5'h11;
   localparam logic [4:0] IDX_BLC = 5'h12;
   localparam logic [4:0] IDX_ANL = 5'h13;
   localparam logic [4:0] IDX_ANH = 5'h14;
   localparam logic [4:0] IDX_VAC = 5'h15;
   localparam logic [4:0] IDX_IOB = 5'h16;
   localparam logic [4:0] IDX_LOC = 5'h17;
   localparam logic [4:0] IDX_NONE = 5'h1F;

   // Field positions
   localparam int FOUR_WIRE_BIT_HI = 4;
   localparam int FOUR_WIRE_BIT_LO = 3;
   localparam int REF_DOUBLER_BIT = 3;
   localparam int REF_HALVE_BIT = 0;
   localparam int FRAC_MOD_EN_BIT = 4;
   localparam int LOCK_GATE_BIT = 1;
   localparam int LOCK_STATUS_BIT = 0;
   localparam int MIX_ENABLE_BIT = 7;
   localparam int LO_DIV_MSB = 4;
   localparam int REF_COUNT_MSB = 6;
   localparam int AUX_HIGH_MSB = 5;
   localparam int PUMP_FIELD_MSB = 3;

   // Divider codes, one-hot
   localparam logic [4:0] DIV_CODE_1 = 5'h01;
   localparam logic [4:0] DIV_CODE_2 = 5'h02;
   localparam logic [4:0] DIV_CODE_4 = 5'h04;
   localparam logic [4:0] DIV_CODE_8 = 5'h08;
   localparam logic [4:0] DIV_CODE_16 = 5'h10;

   // Frame layout
   localparam int ADDR_BITS = 16;
   localparam int DATA_BITS = 8;
   localparam logic [4:0] LAST_ADDR_COUNT = 5'h10;
   localparam logic [4:0] LAST_DATA_COUNT = 5'h18;

   // Calibration time
   localparam int SYS_CLK_MHZ = 50;
   localparam int CAL_TIME_US = 200;
   localparam int CAL_CYCLES = CAL_TIME_US * SYS_CLK_MHZ;

   localparam logic [7:0] REG_RESET = 8'h00;

   // Completed write handed from the serial domain
   typedef struct packed {
      logic [15:0] addr;
      logic [7:0] data;
   } losc_wr_s;

   // Synthesizer settings presented to the analog core
   typedef struct packed {
      logic [4:0] lo_divider_code;
      logic [15:0] whole_divide;
      logic [23:0] primary_fraction_numerator;
      logic [13:0] aux_fraction_numerator;
      logic [13:0] aux_denominator;
      logic [6:0] ref_count;
      logic ref_doubler;
      logic ref_halve;
      logic fractional_modulator_enable;
      logic [3:0] pump_current_field;
      logic [7:0] bleed_current_field;
      logic mixer_enable;
      logic external_lo_select;
   } losc_synth_s;
endpackage : losc_pkg

// File: verilog/losc_ctrl.sv
// LO synthesizer control: serial register port, register file, calibration
// timer and lock reporting. Serial port logic runs on the serial clock; the
// register file runs on sys_clk. The analog PLL sits outside.
// How it works
// - One-hot code selects divide 1 to 16
// - Detector rate uses doubler and halving bits
// - Reference count from bits six to zero
// - Feedback divide from whole and fraction parts
// - Primary numerator from three byte registers
// - Auxiliary numerator fourteen bits, two registers
// - Auxiliary denominator fourteen bits, two registers
// - Bleed field is an eight-bit value
// - Final write starts 200 us calibration
// - Whole divide low write starts calibration
// - Lock shown in status bit and pin
// - Lock visible only while gate bit clear
// - External LO uses divide-by-one path
// - Three-wire default, four-wire when both set
// - Frame starts at select low then clock
// - Select high ignores clock and data
// - Instruction bit, 16 address, 8 data
// - Shared line drives only in read data
`timescale 1ns/10ps
`default_nettype none
module losc_ctrl (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic serial_clk,
   input wire logic select_n,
   input wire logic sdio_in,
   output logic sdio_out,
   output logic sdio_oe,
   output logic serial_out_line,
   output logic serial_out_oe,
   input wire logic pll_locked,
   output logic lock_indicator_pin,
   output logic calibrating,
   output losc_pkg::losc_synth_s synth
);
   // Register storage, indexed by a decoded address
   logic [7:0] regs_ff [losc_pkg::NUM_REGS];

   function automatic logic [4:0] addr_index(input logic [15:0] a);
      unique case (a)
         losc_pkg::ADDR_SERIAL_PORT_CONFIG: addr_index = losc_pkg::IDX_SPC;
         losc_pkg::ADDR_IO_LEVEL_SELECT_A: addr_index = losc_pkg::IDX_IOA;
         losc_pkg::ADDR_SYNTH_BLOCK_ENABLES: addr_index = losc_pkg::IDX_SBE;
         losc_pkg::ADDR_WHOLE_DIVIDE_LOW: addr_index = losc_pkg::IDX_WDL;
         losc_pkg::ADDR_WHOLE_DIVIDE_HIGH: addr_index = losc_pkg::IDX_WDH;
         losc_pkg::ADDR_PRIMARY_FRACTION_LOW: addr_index = losc_pkg::IDX_PFL;
         losc_pkg::ADDR_PRIMARY_FRACTION_MID: addr_index = losc_pkg::IDX_PFM;
         losc_pkg::ADDR_PRIMARY_FRACTION_HIGH: addr_index = losc_pkg::IDX_PFH;
         losc_pkg::ADDR_AUX_DENOMINATOR_LOW: addr_index = losc_pkg::IDX_ADL;
         losc_pkg::ADDR_AUX_DENOMINATOR_HIGH: addr_index = losc_pkg::IDX_ADH;
         losc_pkg::ADDR_FEEDBACK_DIVIDER_CTRL: addr_index = losc_pkg::IDX_FBC;
         losc_pkg::ADDR_REFERENCE_COUNTER: addr_index = losc_pkg::IDX_RCN;
         losc_pkg::ADDR_REFERENCE_PATH_CTRL: addr_index = losc_pkg::IDX_RPC;
         losc_pkg::ADDR_VCO_CORE_SELECT: addr_index = losc_pkg::IDX_VCS;
         losc_pkg::ADDR_CALIBRATION_CTRL: addr_index = losc_pkg::IDX_CAL;
         losc_pkg::ADDR_MODULATOR_CTRL: addr_index = losc_pkg::IDX_MOD;
         losc_pkg::ADDR_DETECTOR_PUMP_ENABLE: addr_index = losc_pkg::IDX_DPE;
         losc_pkg::ADDR_PUMP_CURRENT: addr_index = losc_pkg::IDX_PCU;
         losc_pkg::ADDR_BLEED_CURRENT: addr_index = losc_pkg::IDX_BLC;
         losc_pkg::ADDR_AUX_NUMERATOR_LOW: addr_index = losc_pkg::IDX_ANL;
         losc_pkg::ADDR_AUX_NUMERATOR_HIGH: addr_index = losc_pkg::IDX_ANH;
         losc_pkg::ADDR_VCO_ADJUST_CTRL: addr_index = losc_pkg::IDX_VAC;
         losc_pkg::ADDR_IO_LEVEL_SELECT_B: addr_index = losc_pkg::IDX_IOB;
         losc_pkg::ADDR_LO_OUTPUT_CTRL: addr_index = losc_pkg::IDX_LOC;
         default: addr_index = losc_pkg::IDX_NONE;
      endcase
   endfunction : addr_index

   // ---- Serial clock domain ----
   logic [4:0] bit_cnt_ff;
   logic read_ff;
   logic [15:0] addr_sh_ff;
   logic [7:0] data_sh_ff;
   logic wr_toggle_ff;
   losc_pkg::losc_wr_s wr_hold_ff;
   logic [7:0] rd_data_ff;
   logic [7:0] out_sh_ff;
   logic rd_phase_ff;
   logic four_wire_sclk_ff1;
   logic four_wire_sclk_ff2;
   logic [7:0] rd_sel;
   logic four_wire;

   // Bit counter and instruction capture; select high holds the frame in reset
   always_ff @(posedge serial_clk or posedge select_n) begin
      if (select_n) begin
         bit_cnt_ff <= 5'h00;
         read_ff <= 1'b0;
         addr_sh_ff <= 16'h0000;
         data_sh_ff <= 8'h00;
      end else begin
         // Parks one past the last data bit so stray clocks cannot repeat a write
         if (bit_cnt_ff != losc_pkg::LAST_DATA_COUNT + 5'h01) begin
            bit_cnt_ff <= bit_cnt_ff + 5'h01;
         end
         if (bit_cnt_ff == 5'h00) begin
            read_ff <= sdio_in;
         end else if (bit_cnt_ff <= losc_pkg::LAST_ADDR_COUNT) begin
            addr_sh_ff <= {addr_sh_ff[14:0], sdio_in};
         end else if (bit_cnt_ff < losc_pkg::LAST_DATA_COUNT) begin
            data_sh_ff <= {data_sh_ff[6:0], sdio_in};
         end
      end
   end

   // Completed writes cross by toggle; the word is held stable until next frame
   always_ff @(posedge serial_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_toggle_ff <= 1'b0;
         wr_hold_ff <= '0;
      end else if (!select_n && !read_ff
                   && bit_cnt_ff == losc_pkg::LAST_DATA_COUNT) begin
         wr_toggle_ff <= ~wr_toggle_ff;
         wr_hold_ff <= '{addr: addr_sh_ff, data: {data_sh_ff[6:0], sdio_in}};
      end
   end

   // Readback word is quasi-static register content, sampled when address ends
   always_ff @(posedge serial_clk or negedge arst_n) begin
      if (!arst_n) begin
         rd_data_ff <= 8'h00;
      end else if (bit_cnt_ff == losc_pkg::LAST_ADDR_COUNT) begin
         rd_data_ff <= rd_sel;
      end
   end

   // Mode bit synchronised into the serial domain
   always_ff @(posedge serial_clk or negedge arst_n) begin
      if (!arst_n) begin
         four_wire_sclk_ff1 <= 1'b0;
         four_wire_sclk_ff2 <= 1'b0;
      end else begin
         four_wire_sclk_ff1 <= four_wire;
         four_wire_sclk_ff2 <= four_wire_sclk_ff1;
      end
   end

   // Output shifter changes on the falling edge so the host samples on the rise
   always_ff @(negedge serial_clk or posedge select_n) begin
      if (select_n) begin
         out_sh_ff <= 8'h00;
         rd_phase_ff <= 1'b0;
      end else if (bit_cnt_ff == losc_pkg::LAST_ADDR_COUNT + 5'h01) begin
         out_sh_ff <= rd_data_ff;
         rd_phase_ff <= read_ff;
      end else if (bit_cnt_ff > losc_pkg::LAST_ADDR_COUNT + 5'h01) begin
         out_sh_ff <= {out_sh_ff[6:0], 1'b0};
         rd_phase_ff <= read_ff && bit_cnt_ff != losc_pkg::LAST_DATA_COUNT + 5'h01;
      end
   end

   // Shared line drives only in the read data phase; four-wire uses own line
   assign sdio_out = out_sh_ff[7];
   assign sdio_oe = rd_phase_ff && !four_wire_sclk_ff2 && !select_n;
   assign serial_out_line = out_sh_ff[7];
   assign serial_out_oe = rd_phase_ff && four_wire_sclk_ff2 && !select_n;

   // ---- System clock domain ----
   logic wr_sync_ff1;
   logic wr_sync_ff2;
   logic wr_sync_ff3;
   logic wr_event;
   logic [4:0] wr_idx;
   logic lock_ff1;
   logic lock_ff2;
   logic [$clog2(losc_pkg::CAL_CYCLES+1)-1:0] cal_cnt_ff;
   logic cal_busy_ff;
   logic lock_seen;

   // Toggle synchroniser; third stage only for the edge compare
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wr_sync_ff1 <= 1'b0;
         wr_sync_ff2 <= 1'b0;
         wr_sync_ff3 <= 1'b0;
      end else begin
         wr_sync_ff1 <= wr_toggle_ff;
         wr_sync_ff2 <= wr_sync_ff1;
         wr_sync_ff3 <= wr_sync_ff2;
      end
   end
   assign wr_event = wr_sync_ff2 ^ wr_sync_ff3;
   assign wr_idx = addr_index(wr_hold_ff.addr);

   // Register writes; the status register is read-only and never stored
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int i = 0; i < losc_pkg::NUM_REGS; i++) begin
            regs_ff[i] <= losc_pkg::REG_RESET;
         end
      end else if (wr_event && wr_idx != losc_pkg::IDX_NONE) begin
         regs_ff[wr_idx] <= wr_hold_ff.data;
      end
   end

   // Calibration timer; a new low-divide write restarts it
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_cnt_ff <= '0;
         cal_busy_ff <= 1'b0;
      end else if (wr_event && wr_hold_ff.addr == losc_pkg::ADDR_WHOLE_DIVIDE_LOW) begin
         cal_cnt_ff <= '0;
         cal_busy_ff <= 1'b1;
      end else if (cal_busy_ff) begin
         if (cal_cnt_ff == $bits(cal_cnt_ff)'(losc_pkg::CAL_CYCLES - 1)) begin
            cal_busy_ff <= 1'b0;
         end else begin
            cal_cnt_ff <= cal_cnt_ff + 1'b1;
         end
      end
   end
   assign calibrating = cal_busy_ff;

   // Lock input from the analog loop is asynchronous
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_ff1 <= 1'b0;
         lock_ff2 <= 1'b0;
      end else begin
         lock_ff1 <= pll_locked;
         lock_ff2 <= lock_ff1;
      end
   end

   // Lock reported only outside calibration and with the gate bit clear
   assign lock_seen = lock_ff2 && !cal_busy_ff
                      && !regs_ff[losc_pkg::IDX_MOD][losc_pkg::LOCK_GATE_BIT];
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_indicator_pin <= 1'b0;
      end else begin
         lock_indicator_pin <= lock_seen;
      end
   end

   // Readback mux; unmapped addresses read zero. The last address bit is still
   // on the line when the word is captured, so it joins the shifter here.
   always_comb begin
      logic [4:0] ri;
      logic [15:0] ra;
      ra = {addr_sh_ff[14:0], sdio_in};
      ri = addr_index(ra);
      if (ra == losc_pkg::ADDR_LOCK_STATUS) begin
         rd_sel = {7'h00, lock_indicator_pin};
      end else if (ri == losc_pkg::IDX_NONE) begin
         rd_sel = 8'h00;
      end else begin
         rd_sel = regs_ff[ri];
      end
   end

   // Four-wire needs both mode bits set
   assign four_wire = regs_ff[losc_pkg::IDX_SPC][losc_pkg::FOUR_WIRE_BIT_HI]
                      && regs_ff[losc_pkg::IDX_SPC][losc_pkg::FOUR_WIRE_BIT_LO];

   // Settings to the analog core, straight from the register flops
   always_comb begin
      synth.lo_divider_code = regs_ff[losc_pkg::IDX_LOC][losc_pkg::LO_DIV_MSB:0];
      synth.external_lo_select = regs_ff[losc_pkg::IDX_LOC] == 8'hA1;
      synth.mixer_enable = regs_ff[losc_pkg::IDX_LOC][losc_pkg::MIX_ENABLE_BIT];
      synth.whole_divide = {regs_ff[losc_pkg::IDX_WDH], regs_ff[losc_pkg::IDX_WDL]};
      synth.primary_fraction_numerator = {regs_ff[losc_pkg::IDX_PFH],
         regs_ff[losc_pkg::IDX_PFM], regs_ff[losc_pkg::IDX_PFL]};
      synth.aux_fraction_numerator = {regs_ff[losc_pkg::IDX_ANH][losc_pkg::AUX_HIGH_MSB:0],
         regs_ff[losc_pkg::IDX_ANL]};
      synth.aux_denominator = {regs_ff[losc_pkg::IDX_ADH][losc_pkg::AUX_HIGH_MSB:0],
         regs_ff[losc_pkg::IDX_ADL]};
      synth.ref_count = regs_ff[losc_pkg::IDX_RCN][losc_pkg::REF_COUNT_MSB:0];
      synth.ref_doubler = regs_ff[losc_pkg::IDX_RPC][losc_pkg::REF_DOUBLER_BIT];
      synth.ref_halve = regs_ff[losc_pkg::IDX_RPC][losc_pkg::REF_HALVE_BIT];
      synth.fractional_modulator_enable =
         regs_ff[losc_pkg::IDX_MOD][losc_pkg::FRAC_MOD_EN_BIT];
      synth.pump_current_field = regs_ff[losc_pkg::IDX_PCU][losc_pkg::PUMP_FIELD_MSB:0];
      synth.bleed_current_field = regs_ff[losc_pkg::IDX_BLC];
   end
endmodule : losc_ctrl
`default_nettype wire

// File: verif/losc_ctrl_assertions.sv
// Checker for losc_ctrl: timing relations between its ports, all on sys_clk.
// Assumes the bind at the foot attaches it to every losc_ctrl instance.
`timescale 1ns/10ps
`default_nettype none
module losc_ctrl_chk (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic serial_clk,
   input wire logic select_n,
   input wire logic sdio_in,
   input wire logic sdio_out,
   input wire logic sdio_oe,
   input wire logic serial_out_line,
   input wire logic serial_out_oe,
   input wire logic pll_locked,
   input wire logic lock_indicator_pin,
   input wire logic calibrating,
   input wire losc_pkg::losc_synth_s synth
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   int cal_run_ff;
   int oe_run_ff;
   // Run lengths; a counter avoids unrolling a 10000-cycle repetition
   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cal_run_ff <= 0;
         oe_run_ff <= 0;
      end else begin
         cal_run_ff <= calibrating ? cal_run_ff + 1 : 0;
         oe_run_ff <= (sdio_oe || serial_out_oe) ? oe_run_ff + 1 : 0;
      end
   end
   cal_length_a: assert property ($fell(calibrating) |-> cal_run_ff == losc_pkg::CAL_CYCLES)
      else $error("calibration length wrong");
   cal_start_a: assert property ($changed(synth.whole_divide[7:0]) |-> ##[0:2] calibrating)
      else $error("low divide write did not start calibration");
   lock_cal_a: assert property (calibrating && $past(calibrating) |-> !lock_indicator_pin)
      else $error("lock shown during calibration");
   lock_follow_a: assert property ((!pll_locked) [*5] |=> !lock_indicator_pin)
      else $error("lock shown without loop lock");
   ext_path_a: assert property (synth.external_lo_select |-> synth.lo_divider_code == 5'h01)
      else $error("external path not divide by one");
   quiet_hold_a: assert property (select_n [*8] |=> $stable(synth))
      else $error("settings changed while deselected");
   oe_idle_a: assert property (select_n && $past(select_n) |-> !sdio_oe && !serial_out_oe)
      else $error("data driven while deselected");
   oe_excl_a: assert property (!(sdio_oe && serial_out_oe))
      else $error("both data outputs driven");
   oe_span_a: assert property ($fell(sdio_oe || serial_out_oe) && !select_n |-> oe_run_ff inside {[63:65]})
      else $error("read data phase length wrong");
   cover property ($rose(calibrating));
   cover property ($rose(lock_indicator_pin));
   cover property ($rose(sdio_oe));
   cover property ($rose(serial_out_oe));
endmodule : losc_ctrl_chk
bind losc_ctrl losc_ctrl_chk losc_ctrl_chk_inst (.sys_clk(sys_clk), .arst_n(arst_n),
   .serial_clk(serial_clk), .select_n(select_n), .sdio_in(sdio_in), .sdio_out(sdio_out),
   .sdio_oe(sdio_oe), .serial_out_line(serial_out_line), .serial_out_oe(serial_out_oe),
   .pll_locked(pll_locked), .lock_indicator_pin(lock_indicator_pin),
   .calibrating(calibrating), .synth(synth));
`default_nettype wire

// File: verif/losc_host_model.sv
// Host controller model: shapes serial frames, clock still outside frames.
// Assumes the bench resolves the shared line from host_oe and the device enable.
`timescale 1ns/10ps
`default_nettype none
module losc_host_model (
   output logic serial_clk,
   output logic select_n,
   output logic host_oe,
   output logic host_d,
   input wire logic sdio_in,
   input wire logic serial_out_line,
   input wire logic four_wire
);
   initial begin
      serial_clk = 1'b0;
      select_n = 1'b1;
      host_oe = 1'b0;
      host_d = 1'b0;
   end
   // One frame of nbits; fewer than 25 cuts it short by raising select
   task automatic frame(input logic rd, input logic [15:0] addr, input logic [7:0] wdat,
                        input int nbits, output logic [7:0] rdat);
      logic [24:0] word;
      word = {rd, addr, wdat};
      rdat = 8'h00;
      // Odd lead-in shifts link edges 3 ns against the system clock edges each frame, so some frames land on them
      #83 select_n = 1'b0;
      for (int i = 0; i < nbits; i++) begin
         host_oe = !(rd && i > 16);
         host_d = word[24 - i];
         #80 serial_clk = 1'b1;
         if (rd && i > 16) rdat = {rdat[6:0], four_wire ? serial_out_line : sdio_in};
         #80 serial_clk = 1'b0;
      end
      // Hold select past the last edge so the write can land first
      #160 select_n = 1'b1;
      host_oe = 1'b0;
      #160;
   endtask : frame
endmodule : losc_host_model
`default_nettype wire

// File: verif/tb_top.sv
// Testbench top: host model drives frames, a register mirror predicts results.
// Assumes the checker binds itself to losc_ctrl.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic pll_locked = 1'b0;
   logic four_wire = 1'b0;
   logic flt = 1'b0;
   wire logic serial_clk, select_n, host_oe, host_d, sdio_in, sdio_out, sdio_oe;
   wire logic so_line, so_oe, lock_pin, cal;
   losc_pkg::losc_synth_s synth;
   int n_mismatch = 0;
   int samples_checked = 0;
   logic [7:0] mdl [logic [15:0]];
   logic [15:0] rw_addr [24] = '{16'h0000, 16'h0101, 16'h1021, 16'h1200, 16'h1201, 16'h1202,
      16'h1203, 16'h1204, 16'h1208, 16'h1209, 16'h120B, 16'h120C, 16'h120E, 16'h1217, 16'h121F,
      16'h122A, 16'h122D, 16'h122E, 16'h122F, 16'h1233, 16'h1234, 16'h1240, 16'h1401, 16'h1414};
   logic [23:0] ext_seq [7] = '{24'h12_0B00, 24'h12_2D00, 24'h12_4003, 24'h12_1700,
      24'h12_1F40, 24'h10_21D8, 24'h14_14A1};
   logic [4:0] codes [5] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10};
   logic [7:0] junk;
   always #10 sys_clk = ~sys_clk;
   // A released line toggles, so a stale level can never pass for data
   always @(posedge sys_clk) flt <= ~flt;
   assign sdio_in = sdio_oe ? sdio_out : (host_oe ? host_d : flt);
   losc_ctrl losc_ctrl_inst (.sys_clk(sys_clk), .arst_n(arst_n), .serial_clk(serial_clk),
      .select_n(select_n), .sdio_in(sdio_in), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
      .serial_out_line(so_line), .serial_out_oe(so_oe), .pll_locked(pll_locked),
      .lock_indicator_pin(lock_pin), .calibrating(cal), .synth(synth));
   losc_host_model losc_host_model_inst (.serial_clk(serial_clk), .select_n(select_n),
      .host_oe(host_oe), .host_d(host_d), .sdio_in(sdio_in), .serial_out_line(so_line),
      .four_wire(four_wire));
   task automatic report_and_stop();
      $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
      if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : check
   // Settings bus predicted field by field from the mirror
   task automatic chk_synth();
      losc_pkg::losc_synth_s s;
      s.lo_divider_code = mdl[16'h1414][4:0];
      s.whole_divide = {mdl[16'h1201], mdl[16'h1200]};
      s.primary_fraction_numerator = {mdl[16'h1204], mdl[16'h1203], mdl[16'h1202]};
      s.aux_fraction_numerator = {mdl[16'h1234][5:0], mdl[16'h1233]};
      s.aux_denominator = {mdl[16'h1209][5:0], mdl[16'h1208]};
      s.ref_count = mdl[16'h120C][6:0];
      s.ref_doubler = mdl[16'h120E][3];
      s.ref_halve = mdl[16'h120E][0];
      s.fractional_modulator_enable = mdl[16'h122A][4];
      s.pump_current_field = mdl[16'h122E][3:0];
      s.bleed_current_field = mdl[16'h122F];
      s.mixer_enable = mdl[16'h1414][7];
      s.external_lo_select = (mdl[16'h1414] == 8'hA1);
      samples_checked++;
      if (synth !== s) begin
         n_mismatch++;
         $display("BAD %0t settings bus got %h expected %h", $time, synth, s);
      end
   endtask : chk_synth
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      losc_host_model_inst.frame(1'b0, a, d, 25, junk);
      if (mdl.exists(a)) mdl[a] = d;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] got;
      losc_host_model_inst.frame(1'b1, a, 8'h00, 25, got);
      check(got, exp);
   endtask : rd
   task automatic wait_cal(input logic lvl, input int lim);
      int k;
      for (k = 0; k < lim && cal !== lvl; k++) @(posedge sys_clk);
      if (k == lim) begin
         n_mismatch++;
         $display("BAD %0t calibration wait ran out", $time);
         report_and_stop();
      end
   endtask : wait_cal
   initial begin
      int unsigned seed;
      seed = $urandom(86);
      foreach (rw_addr[i]) mdl[rw_addr[i]] = 8'h00;
      repeat (4) @(posedge sys_clk);
      #2 arst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      // Every register and the settings bus come out of reset cleared
      foreach (rw_addr[i]) rd(rw_addr[i], 8'h00);
      chk_synth();
      // Random contents through all writable registers except port mode
      // Whole divide high byte kept 1..127 so the value stays in prescaler range
      foreach (rw_addr[i]) if (i > 0) wr(rw_addr[i], (rw_addr[i] == 16'h1201) ?
         {1'b0, 7'($urandom) | 7'h01} : 8'($urandom));
      foreach (rw_addr[i]) rd(rw_addr[i], mdl[rw_addr[i]]);
      chk_synth();
      foreach (codes[i]) begin
         wr(16'h1414, {3'h0, codes[i]});
         chk_synth();
      end
      // Unmapped place and a frame cut one bit short change nothing
      wr(16'h1300, 8'h5A);
      rd(16'h1300, 8'h00);
      losc_host_model_inst.frame(1'b0, 16'h1208, ~mdl[16'h1208], 24, junk);
      rd(16'h1208, mdl[16'h1208]);
      chk_synth();
      // Calibration and lock reporting
      wait_cal(1'b0, 12000);
      @(posedge sys_clk);
      #2 pll_locked = 1'b1;
      wr(16'h122A, 8'h10);
      wr(16'h122E, 8'h07);
      wr(16'h1200, 8'h4B);
      check({7'h0, cal}, 8'h01);
      check({7'h0, lock_pin}, 8'h00);
      wait_cal(1'b0, 10100);
      repeat (5) @(posedge sys_clk);
      check({7'h0, lock_pin}, 8'h01);
      rd(16'h124D, 8'h01);
      wr(16'h124D, 8'h00);
      rd(16'h124D, 8'h01);
      wr(16'h122A, 8'h12);
      check({7'h0, lock_pin}, 8'h00);
      rd(16'h124D, 8'h00);
      wr(16'h1414, 8'h80);
      chk_synth();
      // External oscillator sequence in order
      foreach (ext_seq[i]) wr(ext_seq[i][23:8], ext_seq[i][7:0]);
      chk_synth();
      // Separate read output once both mode bits are set
      wr(16'h0000, 8'h18);
      four_wire = 1'b1;
      rd(16'h120C, mdl[16'h120C]);
      rd(16'h0000, 8'h18);
      @(posedge sys_clk);
      #2 pll_locked = 1'b0;
      report_and_stop();
   end
endmodule : tb_top
`default_nettype wire
